// ### rtl/kpt_pkg.sv
// Package for the partner training register bank: register indices, field positions,
// reset values, coefficient codes and the shared coefficient step function.
// Assumes a 32-bit AXI4-Lite register bus with one aligned word per register index.
package kpt_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [13:0] REG_IDX_CTRL = 14'h04D0;
    localparam logic [13:0] REG_IDX_EXCH = 14'h04D4;
    localparam logic [13:0] REG_IDX_TAP = 14'h04D5;
    localparam int ADDR_W = 16;

    // Field positions inside the exchange register.
    localparam int EXCH_REQ_LSB = 16;
    localparam int EXCH_INIT_BIT = 22;
    localparam int EXCH_PRESET_BIT = 23;
    localparam int EXCH_REPORT_LSB = 24;
    localparam int EXCH_RXRDY_BIT = 30;
    localparam int EXCH_WR_LANE = 2;

    // Field positions inside the tap readout and control registers.
    localparam int TAP_SWING_LSB = 0;
    localparam int TAP_POST_LSB = 8;
    localparam int CTRL_TRAIN_EN_BIT = 0;
    localparam int CTRL_LOCAL_RPT_LSB = 8;

    // Bit positions inside the received training frame words.
    localparam int FRM_INIT_BIT = 12;
    localparam int FRM_PRESET_BIT = 13;
    localparam int FRM_RXRDY_BIT = 15;

    // Reset values.
    localparam logic CTRL_TRAIN_EN_RST = 1'b1;
    localparam logic [5:0] EXCH_REQ_RST = 6'h00;
    localparam logic [5:0] EXCH_REPORT_RST = 6'h00;

    // Tap limits, initialize and preset values.
    localparam logic [4:0] SWING_MIN = 5'h00;
    localparam logic [4:0] SWING_MAX = 5'h1F;
    localparam logic [4:0] SWING_INIT = 5'h14;
    localparam logic [4:0] SWING_PRESET = 5'h1F;
    localparam logic [5:0] POST_MIN = 6'h00;
    localparam logic [5:0] POST_MAX = 6'h3F;
    localparam logic [5:0] POST_INIT = 6'h10;
    localparam logic [5:0] POST_PRESET = 6'h00;

    // Coefficient update request codes.
    localparam logic [1:0] UPD_HOLD = 2'h0;
    localparam logic [1:0] UPD_INC = 2'h1;
    localparam logic [1:0] UPD_DEC = 2'h2;
    localparam logic [1:0] UPD_RSVD = 2'h3;

    // Coefficient status report codes.
    localparam logic [1:0] RPT_NOT_UPD = 2'h0;
    localparam logic [1:0] RPT_MIN = 2'h1;
    localparam logic [1:0] RPT_UPD = 2'h2;
    localparam logic [1:0] RPT_MAX = 2'h3;

    // Bus response codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Steps one coefficient; returns {report, new value}. Reserved acts as hold.
    function automatic logic [7:0] coefStep(input logic [1:0] code, input logic [5:0] val,
                                            input logic [5:0] lo, input logic [5:0] hi);
        logic [7:0] res;
        res = {RPT_NOT_UPD, val};
        case (code)
            UPD_INC: begin
                if (val >= hi) res = {RPT_MAX, val};
                else res = {RPT_UPD, 6'(val + 6'h01)};
            end
            UPD_DEC: begin
                if (val <= lo) res = {RPT_MIN, val};
                else res = {RPT_UPD, 6'(val - 6'h01)};
            end
            default: res = {RPT_NOT_UPD, val};
        endcase
        return res;
    endfunction : coefStep

endpackage : kpt_pkg

// ### rtl/kpt_axil_slave.sv
// AXI4-Lite slave front end: one write and one read under way at a time.
// Assumes the register file decodes the address and answers within the same cycle.
`timescale 1ns/1ps
module kpt_axil_slave #(
    parameter int AW = kpt_pkg::ADDR_W
) (
    input wire logic clock,
    input wire logic rstN,
    input wire logic [AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic wrEn,
    output logic [AW-1:0] wrAddr,
    output logic [31:0] wrData,
    output logic [3:0] wrStrb,
    input wire logic wrOk,
    output logic [AW-1:0] rdAddr,
    input wire logic [31:0] rdData,
    input wire logic rdOk
);

    logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic rdEn;

    // Address and data are taken together, which keeps the write path free of holding regs.
    assign awready = awvalid && wvalid && !bvalid_r;
    assign wready = awready;
    assign wrEn = awready;
    assign wrAddr = awaddr;
    assign wrData = wdata;
    assign wrStrb = wstrb;
    assign arready = !rvalid_r;
    assign rdEn = arvalid && arready;
    assign rdAddr = araddr;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign rvalid = rvalid_r;
    assign rresp = rresp_r;
    assign rdata = rdata_r;

    // Response channels hold until the master accepts them.
    always_comb begin
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        if (bvalid_r && bready) bvalid_nxt = 1'b0;
        if (wrEn) begin
            bvalid_nxt = 1'b1;
            bresp_nxt = wrOk ? kpt_pkg::RESP_OKAY : kpt_pkg::RESP_SLVERR;
        end
        if (rvalid_r && rready) rvalid_nxt = 1'b0;
        if (rdEn) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = rdOk ? kpt_pkg::RESP_OKAY : kpt_pkg::RESP_SLVERR;
            rdata_nxt = rdOk ? rdData : 32'h00000000;
        end
    end

    // Response registers.
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            bvalid_r <= 1'b0;
            bresp_r <= 2'h0;
            rvalid_r <= 1'b0;
            rresp_r <= 2'h0;
            rdata_r <= 32'h00000000;
        end else begin
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
        end
    end

endmodule : kpt_axil_slave

// ### rtl/kpt_tap_update.sv
// Transmit tap update logic: applies partner update, initialize and preset requests.
// Assumes apply is a one-cycle pulse with the request inputs stable in that cycle.
`timescale 1ns/1ps
module kpt_tap_update #(
    parameter logic [4:0] SW_MIN = kpt_pkg::SWING_MIN,
    parameter logic [4:0] SW_MAX = kpt_pkg::SWING_MAX,
    parameter logic [4:0] SW_INIT = kpt_pkg::SWING_INIT,
    parameter logic [4:0] SW_PRESET = kpt_pkg::SWING_PRESET,
    parameter logic [5:0] PT_MIN = kpt_pkg::POST_MIN,
    parameter logic [5:0] PT_MAX = kpt_pkg::POST_MAX,
    parameter logic [5:0] PT_INIT = kpt_pkg::POST_INIT,
    parameter logic [5:0] PT_PRESET = kpt_pkg::POST_PRESET
) (
    input wire logic clock,
    input wire logic rstN,
    input wire logic apply,
    input wire logic [5:0] request,
    input wire logic initReq,
    input wire logic presetReq,
    output logic [4:0] swing,
    output logic [5:0] postTap,
    output logic [5:0] localReport
);

    logic [4:0] swing_r, swing_nxt;
    logic [5:0] post_r, post_nxt, rpt_r, rpt_nxt;
    logic [7:0] stepP, stepC, stepM;

    // Plus-one steers the post tap, center steers swing; the pre tap is not held here,
    // so minus-one increment answers maximum, decrement minimum, and hold or reserved not updated.
    assign stepP = kpt_pkg::coefStep(request[5:4], post_r, PT_MIN, PT_MAX);
    assign stepC = kpt_pkg::coefStep(request[3:2], {1'b0, swing_r}, {1'b0, SW_MIN},
                                     {1'b0, SW_MAX});
    assign stepM = kpt_pkg::coefStep(request[1:0], 6'h00, 6'h00, 6'h00);

    // Preset wins over initialize, which wins over step requests.
    always_comb begin
        swing_nxt = swing_r;
        post_nxt = post_r;
        rpt_nxt = rpt_r;
        if (apply) begin
            if (presetReq) begin
                swing_nxt = SW_PRESET;
                post_nxt = PT_PRESET;
                rpt_nxt = {3{kpt_pkg::RPT_NOT_UPD}};
            end else if (initReq) begin
                swing_nxt = SW_INIT;
                post_nxt = PT_INIT;
                rpt_nxt = {3{kpt_pkg::RPT_NOT_UPD}};
            end else begin
                post_nxt = stepP[5:0];
                swing_nxt = stepC[4:0];
                rpt_nxt = {stepP[7:6], stepC[7:6], stepM[7:6]};
            end
        end
    end

    // Tap registers start from the initialize values.
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            swing_r <= SW_INIT;
            post_r <= PT_INIT;
            rpt_r <= 6'h00;
        end else begin
            swing_r <= swing_nxt;
            post_r <= post_nxt;
            rpt_r <= rpt_nxt;
        end
    end

    assign swing = swing_r;
    assign postTap = post_r;
    assign localReport = rpt_r;

endmodule : kpt_tap_update

// ### rtl/kpt_training_regs.sv
// Partner training register bank: control, partner exchange and trained tap readout.
// Assumes received training frames arrive as a one-cycle strobe with both 16-bit words.
//
// How it works
// - Update field follows each received frame's first word while training on; writable only while training off.
// - Plus-one update code 11 reserved, 01 increments, 10 decrements.
// - Center and minus-one update subfields use the same encoding as plus-one.
// - Initialize request set loads initialize transmit coefficients; clear means normal.
// - Preset request set loads preset coefficients turning equalization off.
// - Read-only report field shows each received frame's second word.
// - Status codes: 11 maximum, 01 minimum, 10 updated, 00 not updated.
// - Receiver-ready bit shows the partner's training-complete flag from the frame.
// - Read-only field holds the latest trained transmit swing setting.
// - Read-only field holds the latest trained transmit post-tap setting.
`timescale 1ns/1ps
module kpt_training_regs #(
    parameter int AW = kpt_pkg::ADDR_W
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic frameValid,
    input wire logic [15:0] frameUpdateWord,
    input wire logic [15:0] frameStatusWord,
    output logic [5:0] partnerCoefRequest,
    output logic partnerInitRequest,
    output logic partnerPresetRequest,
    output logic [5:0] partnerCoefReport,
    output logic partnerRxTrained,
    output logic [4:0] trainedSwingValue,
    output logic [5:0] trainedPostTapValue,
    output logic [5:0] localCoefReport,
    output logic trainingEnableCtl
);

    localparam logic [AW-1:0] ADDR_CTRL = AW'({kpt_pkg::REG_IDX_CTRL, 2'b00});
    localparam logic [AW-1:0] ADDR_EXCH = AW'({kpt_pkg::REG_IDX_EXCH, 2'b00});
    localparam logic [AW-1:0] ADDR_TAP = AW'({kpt_pkg::REG_IDX_TAP, 2'b00});

    logic [1:0] rstSync_r;
    logic rstN;
    logic wrEn, wrOk, rdOk;
    logic [AW-1:0] wrAddr, rdAddr;
    logic [31:0] wrData, rdData;
    logic [3:0] wrStrb;
    logic trainEn_r, trainEn_nxt;
    logic [5:0] req_r, req_nxt, report_r, report_nxt;
    logic init_r, init_nxt, preset_r, preset_nxt, rxRdy_r, rxRdy_nxt;
    logic apply_r, apply_nxt;
    logic swWrExch;

    // Reset is released through two flops so every register leaves reset on the same edge.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) rstSync_r <= 2'b00;
        else rstSync_r <= {rstSync_r[0], 1'b1};
    end
    assign rstN = rstSync_r[1];

    kpt_axil_slave #(.AW(AW)) uBus (
        .clock(clock),
        .rstN(rstN),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .wrEn(wrEn),
        .wrAddr(wrAddr),
        .wrData(wrData),
        .wrStrb(wrStrb),
        .wrOk(wrOk),
        .rdAddr(rdAddr),
        .rdData(rdData),
        .rdOk(rdOk)
    );

    // Address decode; anything outside the three words answers with a slave error.
    assign wrOk = (wrAddr == ADDR_CTRL) || (wrAddr == ADDR_EXCH) || (wrAddr == ADDR_TAP);
    assign rdOk = (rdAddr == ADDR_CTRL) || (rdAddr == ADDR_EXCH) || (rdAddr == ADDR_TAP);
    assign swWrExch = wrEn && (wrAddr == ADDR_EXCH) && wrStrb[kpt_pkg::EXCH_WR_LANE];

    // Exchange fields: frames drive them while training runs, software only when it is off.
    // A frame in the same cycle as a write while training is off still updates the report
    // and ready bits, since those are never software writable.
    always_comb begin
        trainEn_nxt = trainEn_r;
        req_nxt = req_r;
        init_nxt = init_r;
        preset_nxt = preset_r;
        report_nxt = report_r;
        rxRdy_nxt = rxRdy_r;
        apply_nxt = 1'b0;
        if (wrEn && (wrAddr == ADDR_CTRL) && wrStrb[0]) begin
            trainEn_nxt = wrData[kpt_pkg::CTRL_TRAIN_EN_BIT];
        end
        if (trainEn_r) begin
            if (frameValid) begin
                req_nxt = frameUpdateWord[5:0];
                init_nxt = frameUpdateWord[kpt_pkg::FRM_INIT_BIT];
                preset_nxt = frameUpdateWord[kpt_pkg::FRM_PRESET_BIT];
                apply_nxt = 1'b1;
            end
        end else if (swWrExch) begin
            req_nxt = wrData[kpt_pkg::EXCH_REQ_LSB +: 6];
            init_nxt = wrData[kpt_pkg::EXCH_INIT_BIT];
            preset_nxt = wrData[kpt_pkg::EXCH_PRESET_BIT];
            apply_nxt = 1'b1;
        end
        if (frameValid) begin
            report_nxt = frameStatusWord[5:0];
            rxRdy_nxt = frameStatusWord[kpt_pkg::FRM_RXRDY_BIT];
        end
    end

    // Exchange and control registers; an exchange write while training runs leaves the request fields alone.
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            trainEn_r <= kpt_pkg::CTRL_TRAIN_EN_RST;
            req_r <= kpt_pkg::EXCH_REQ_RST;
            init_r <= 1'b0;
            preset_r <= 1'b0;
            report_r <= kpt_pkg::EXCH_REPORT_RST;
            rxRdy_r <= 1'b0;
            apply_r <= 1'b0;
        end else begin
            trainEn_r <= trainEn_nxt;
            req_r <= req_nxt;
            init_r <= init_nxt;
            preset_r <= preset_nxt;
            report_r <= report_nxt;
            rxRdy_r <= rxRdy_nxt;
            apply_r <= apply_nxt;
        end
    end

    // Taps move one cycle after the request fields are registered.
    kpt_tap_update uTap (
        .clock(clock),
        .rstN(rstN),
        .apply(apply_r),
        .request(req_r),
        .initReq(init_r),
        .presetReq(preset_r),
        .swing(trainedSwingValue),
        .postTap(trainedPostTapValue),
        .localReport(localCoefReport)
    );

    // Read data; local-device fields outside this bank read as zero.
    always_comb begin
        rdData = 32'h00000000;
        if (rdAddr == ADDR_CTRL) begin
            rdData[kpt_pkg::CTRL_TRAIN_EN_BIT] = trainEn_r;
            rdData[kpt_pkg::CTRL_LOCAL_RPT_LSB +: 6] = localCoefReport;
        end else if (rdAddr == ADDR_EXCH) begin
            rdData[kpt_pkg::EXCH_REQ_LSB +: 6] = req_r;
            rdData[kpt_pkg::EXCH_INIT_BIT] = init_r;
            rdData[kpt_pkg::EXCH_PRESET_BIT] = preset_r;
            rdData[kpt_pkg::EXCH_REPORT_LSB +: 6] = report_r;
            rdData[kpt_pkg::EXCH_RXRDY_BIT] = rxRdy_r;
        end else if (rdAddr == ADDR_TAP) begin
            rdData[kpt_pkg::TAP_SWING_LSB +: 5] = trainedSwingValue;
            rdData[kpt_pkg::TAP_POST_LSB +: 6] = trainedPostTapValue;
        end
    end

    assign partnerCoefRequest = req_r;
    assign partnerInitRequest = init_r;
    assign partnerPresetRequest = preset_r;
    assign partnerCoefReport = report_r;
    assign partnerRxTrained = rxRdy_r;
    assign trainingEnableCtl = trainEn_r;

    // Checks on the bank's own behaviour.
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstN);

    logic stepOnly;
    assign stepOnly = apply_r && !init_r && !preset_r;

    property p_req_frame;
        trainEn_r && frameValid |=> req_r == $past(frameUpdateWord[5:0]);
    endproperty
    a_req_frame: assert property (p_req_frame) else $error("Update field missed frame.");

    property p_inc_post;
        stepOnly && req_r[5:4] == kpt_pkg::UPD_INC && trainedPostTapValue != kpt_pkg::POST_MAX
        |=> trainedPostTapValue == 6'($past(trainedPostTapValue) + 6'h01);
    endproperty
    a_inc_post: assert property (p_inc_post) else $error("Post tap did not increment.");

    property p_dec_swing;
        stepOnly && req_r[3:2] == kpt_pkg::UPD_DEC && trainedSwingValue != kpt_pkg::SWING_MIN
        |=> trainedSwingValue == 5'($past(trainedSwingValue) - 5'h01);
    endproperty
    a_dec_swing: assert property (p_dec_swing) else $error("Swing did not decrement.");

    property p_init;
        apply_r && init_r && !preset_r |=> trainedSwingValue == kpt_pkg::SWING_INIT
            && trainedPostTapValue == kpt_pkg::POST_INIT;
    endproperty
    a_init: assert property (p_init) else $error("Initialize values not loaded.");

    property p_preset;
        frameValid && trainEn_r && frameUpdateWord[kpt_pkg::FRM_PRESET_BIT]
        |=> ##1 trainedPostTapValue == kpt_pkg::POST_PRESET
            && trainedSwingValue == kpt_pkg::SWING_PRESET;
    endproperty
    a_preset: assert property (p_preset) else $error("Preset values not loaded.");

    property p_report;
        frameValid |=> partnerCoefReport == $past(frameStatusWord[5:0]);
    endproperty
    a_report: assert property (p_report) else $error("Report field missed frame.");

    property p_rpt_max;
        stepOnly && req_r[5:4] == kpt_pkg::UPD_INC && trainedPostTapValue == kpt_pkg::POST_MAX
        |=> localCoefReport[5:4] == kpt_pkg::RPT_MAX;
    endproperty
    a_rpt_max: assert property (p_rpt_max) else $error("Maximum not reported.");

    property p_rx_ready;
        frameValid |=> partnerRxTrained == $past(frameStatusWord[kpt_pkg::FRM_RXRDY_BIT]);
    endproperty
    a_rx_ready: assert property (p_rx_ready) else $error("Ready bit missed frame.");

    property p_swing_read;
        arvalid && arready && araddr == ADDR_TAP
        |=> rdata[4:0] == $past(trainedSwingValue) && rvalid;
    endproperty
    a_swing_read: assert property (p_swing_read) else $error("Swing readout wrong.");

    property p_post_read;
        arvalid && arready && araddr == ADDR_TAP
        |=> rdata[13:8] == $past(trainedPostTapValue) && rresp == kpt_pkg::RESP_OKAY;
    endproperty
    a_post_read: assert property (p_post_read) else $error("Post readout wrong.");

    property p_hold;
        stepOnly && req_r[5:4] == kpt_pkg::UPD_HOLD |=> $stable(trainedPostTapValue);
    endproperty
    a_hold: assert property (p_hold) else $error("Hold changed post tap.");

    property p_sw_ignored;
        trainEn_r && !frameValid && swWrExch |=> $stable(req_r) && $stable(init_r);
    endproperty
    a_sw_ignored: assert property (p_sw_ignored) else $error("Write leaked in.");

    c_frame_apply: cover property (trainEn_r && frameValid ##2 localCoefReport != 6'h00);
    c_sw_update: cover property (!trainEn_r && swWrExch ##2 trainedPostTapValue != 6'h10);
    c_bad_addr: cover property (rvalid && rresp == kpt_pkg::RESP_SLVERR);
    c_rx_trained: cover property ($rose(partnerRxTrained));

endmodule : kpt_training_regs

// ### bench/kpt_frame_src.sv
// Link partner model: sends one training frame for each cycle that go is high.
// Assumes the bench changes go and both words right after a rising edge.
`timescale 1ns/1ps
module kpt_frame_src (
    input wire logic clock,
    input wire logic go,
    input wire logic [15:0] upd,
    input wire logic [15:0] sts,
    output logic frameValid,
    output logic [15:0] frameUpdateWord,
    output logic [15:0] frameStatusWord
);
    // Outside a frame the words carry the inverse, so a stale copy cannot pass by luck.
    always_ff @(posedge clock) begin
        frameValid <= go;
        frameUpdateWord <= go ? upd : ~upd;
        frameStatusWord <= go ? sts : ~sts;
    end
endmodule : kpt_frame_src

// ### bench/kpt_training_regs_tb.sv
// Self-checking bench for the partner training register bank.
// Assumes a 20 MHz clock; frames come from the partner model, registers via AXI4-Lite.
`timescale 1ns/1ps
module kpt_training_regs_tb;
    typedef struct packed {logic [15:0] u; logic [15:0] s; logic [4:0] sw; logic [5:0] pt;
        logic [5:0] lr;} kpt_row_t;
    kpt_row_t rows [12];
    logic clock, reset_n, awvalid, wvalid, bready, arvalid, rready, go;
    logic awready, wready, bvalid, arready, rvalid, frameValid, initRq, presetRq, rxTr, trEn;
    logic [15:0] awaddr, araddr, upd, sts, fUpd, fSts;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    logic [5:0] coefRq, coefRpt, postTap, locRpt;
    logic [4:0] swing;
    int failCount = 0;
    int checksDone = 0;
    localparam logic [15:0] A_CTRL = {kpt_pkg::REG_IDX_CTRL, 2'b00};
    localparam logic [15:0] A_EXCH = {kpt_pkg::REG_IDX_EXCH, 2'b00};
    localparam logic [15:0] A_TAP = {kpt_pkg::REG_IDX_TAP, 2'b00};

    kpt_frame_src PART (.clock(clock), .go(go), .upd(upd), .sts(sts), .frameValid(frameValid),
        .frameUpdateWord(fUpd), .frameStatusWord(fSts));
    kpt_training_regs DUT (.clock(clock), .reset_n(reset_n), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .frameValid(frameValid), .frameUpdateWord(fUpd), .frameStatusWord(fSts),
        .partnerCoefRequest(coefRq), .partnerInitRequest(initRq),
        .partnerPresetRequest(presetRq), .partnerCoefReport(coefRpt), .partnerRxTrained(rxTr),
        .trainedSwingValue(swing), .trainedPostTapValue(postTap), .localCoefReport(locRpt),
        .trainingEnableCtl(trEn));

    // Free-running bench clock, 50 ns period.
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checksDone++;
        if (s !== e) begin
            failCount++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic endOfTest();
        if (failCount == 0 && checksDone > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : endOfTest

    // Write holds address and data until taken, then waits for the response.
    task automatic wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clock);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do @(posedge clock); while (awready !== 1'b1);
        awvalid <= 1'b0; wvalid <= 1'b0;
        do @(posedge clock); while (bvalid !== 1'b1);
        r = bresp; bready <= 1'b0;
        repeat (2) @(posedge clock);
    endtask : wr

    task automatic rdw(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clock);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do @(posedge clock); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clock); while (rvalid !== 1'b1);
        d = rdata; r = rresp; rready <= 1'b0;
    endtask : rdw

    // One frame, then enough edges for the taps to settle.
    task automatic frame(input logic [15:0] u, input logic [15:0] s);
        @(posedge clock);
        go <= 1'b1; upd <= u; sts <= s;
        @(posedge clock);
        go <= 1'b0;
        repeat (4) @(posedge clock);
    endtask : frame

    // Watchdog well above the hundred and some cycles the run needs.
    initial begin
        repeat (5000) @(posedge clock);
        failCount++;
        endOfTest();
    end

    initial begin
        rows = '{'{16'h0004, 16'h8033, 5'h15, 6'h10, 6'h08}, '{16'h0010, 16'h0015, 5'h15, 6'h11, 6'h20},
            '{16'h0020, 16'h002A, 5'h15, 6'h10, 6'h20}, '{16'h0008, 16'h0000, 5'h14, 6'h10, 6'h08},
            '{16'h0000, 16'h8033, 5'h14, 6'h10, 6'h00}, '{16'h003F, 16'h0015, 5'h14, 6'h10, 6'h00},
            '{16'h0001, 16'h002A, 5'h14, 6'h10, 6'h03}, '{16'h0002, 16'h0000, 5'h14, 6'h10, 6'h01},
            '{16'h2000, 16'h8033, 5'h1F, 6'h00, 6'h00}, '{16'h0004, 16'h0015, 5'h1F, 6'h00, 6'h0C},
            '{16'h0020, 16'h002A, 5'h1F, 6'h00, 6'h10}, '{16'h1000, 16'h0000, 5'h14, 6'h10, 6'h00}};
        reset_n = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
        rready = 1'b0; go = 1'b0; awaddr = 16'h0000; araddr = 16'h0000; upd = 16'h0000;
        sts = 16'h0000; wdata = 32'h0000_0000; wstrb = 4'hF;
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        repeat (3) @(posedge clock);
        chk("trEn", 32'(trEn), 32'h1);
        rdw(A_TAP, rd, resp);
        chk("tap", rd, 32'h0000_1014);
        rdw(A_CTRL, rd, resp);
        chk("ctrl", rd, 32'h0000_0001);
        // Frames with training on, including one preset and one initialize request.
        foreach (rows[i]) begin
            frame(rows[i].u, rows[i].s);
            chk("req", 32'(coefRq), 32'(rows[i].u[5:0]));
            chk("init", 32'(initRq), 32'(rows[i].u[12]));
            chk("preset", 32'(presetRq), 32'(rows[i].u[13]));
            chk("rpt", 32'(coefRpt), 32'(rows[i].s[5:0]));
            chk("rxrdy", 32'(rxTr), 32'(rows[i].s[15]));
            chk("swing", 32'(swing), 32'(rows[i].sw));
            chk("post", 32'(postTap), 32'(rows[i].pt));
            chk("locrpt", 32'(locRpt), 32'(rows[i].lr));
        end
        wr(A_EXCH, 32'h00BF_0000, resp);
        chk("bresp", 32'(resp), 32'(kpt_pkg::RESP_OKAY));
        rdw(A_EXCH, rd, resp);
        chk("exch", rd, 32'h0040_0000);
        wr(16'h1360, 32'hFFFF_FFFF, resp);
        chk("bresp", 32'(resp), 32'(kpt_pkg::RESP_SLVERR));
        rdw(16'h1360, rd, resp);
        chk("rdata", rd, 32'h0000_0000);
        chk("rresp", 32'(resp), 32'(kpt_pkg::RESP_SLVERR));
        // Training off: frames no longer drive requests, software does.
        wr(A_CTRL, 32'h0000_0000, resp);
        chk("trEn", 32'(trEn), 32'h0);
        frame(16'h0004, 16'h8033);
        chk("req", 32'(coefRq), 32'h0);
        chk("rxrdy", 32'(rxTr), 32'h1);
        wr(A_EXCH, 32'h0010_0000, resp);
        chk("post", 32'(postTap), 32'h11);
        rdw(A_CTRL, rd, resp);
        chk("ctrl", rd, 32'h0000_2000);
        wr(A_EXCH, 32'h0080_0000, resp);
        chk("swing", 32'(swing), 32'h1F);
        rdw(A_EXCH, rd, resp);
        chk("exch", rd, 32'h7380_0000);
        // A reset in mid-run must bring back the enable and the initialize taps.
        reset_n <= 1'b0;
        repeat (2) @(posedge clock);
        chk("trEn", 32'(trEn), 32'h1);
        chk("swing", 32'(swing), 32'(kpt_pkg::SWING_INIT));
        chk("post", 32'(postTap), 32'(kpt_pkg::POST_INIT));
        reset_n <= 1'b1;
        repeat (3) @(posedge clock);
        endOfTest();
    end
endmodule : kpt_training_regs_tb
